// ===== hw/cotr_params.svh
// Register offsets, field positions and reset values of the offset trim bank
`ifndef COTR_PARAMS_SVH
`define COTR_PARAMS_SVH
`define COTR_ADDR_C_INB_LO 12'h090
`define COTR_ADDR_C_INB_HI 12'h091
`define COTR_ADDR_B_INA_LO 12'h092
`define COTR_ADDR_B_INA_HI 12'h093
`define COTR_ADDR_B_INB_LO 12'h094
`define COTR_ADDR_B_INB_HI 12'h095
`define COTR_ADDR_FILT0 12'h097
`define COTR_ADDR_FILT1 12'h098
`define COTR_ADDR_CAL_CTRL 12'h0a0
`define COTR_ADDR_CAL_STAT 12'h0a1
`define COTR_FILT0_RESET 8'h00
`define COTR_FILT1_RESET 8'h33
`define COTR_TRIM_MSB 11
`define COTR_RSVD_RESET 4'h0
`define COTR_KEEP_NEAR_ZERO_FREQ_CONTENT_BIT 0
`define COTR_OFFSET_CAL_ENABLE_BIT 0
`define COTR_BACKGROUND_CAL_ENABLE_BIT 1
`define COTR_BACKGROUND_OFFSET_CAL_ENABLE_BIT 2
`define COTR_OFFSET_FILTER_ENABLE_BIT 3
`define COTR_FOREGROUND_COMPLETE_FLAG_BIT 0
`define COTR_CAL_HALT_BIT 1
`define COTR_FG_RUN_BIT 2
`endif

// ===== hw/cotr_pkg.sv
// Types shared by the offset trim bank
package cotr_pkg;
   typedef logic [11:0] cotr_trim_t;
   typedef logic [15:0] cotr_word_t;
   typedef enum logic [2:0] {
      COTR_FILT_OFF = 3'b001,
      COTR_FILT_ALL = 3'b010,
      COTR_FILT_MISMATCH = 3'b100
   } cotr_filt_mode_t;
endpackage

// ===== hw/cotr_trim_reg.sv
// One 16-bit offset trim register written a byte at a time
`timescale 1ns/1ps
module cotr_trim_reg
   import cotr_pkg::*;
(
   input wire logic sys_clk_i, // Clock
   input wire logic reset_i, // Sync reset
   input wire logic [11:0] factory_i, // Factory trim value
   input wire logic load_i, // Load factory value
   input wire logic wr_lo_i, // Write low byte
   input wire logic wr_hi_i, // Write high byte
   input wire logic [7:0] wdata_i, // Byte data
   output logic [15:0] value_o // Register content
);
`include "cotr_params.svh"
   cotr_word_t value;
   cotr_word_t next_value;
   always_comb begin
      next_value = value;
      if (load_i) begin
         next_value = {`COTR_RSVD_RESET, factory_i};
      end else begin
         if (wr_lo_i) begin
            next_value[7:0] = wdata_i;
         end
         if (wr_hi_i) begin
            next_value[15:8] = wdata_i;
         end
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         value <= {`COTR_RSVD_RESET, 12'h000};
      end else begin
         value <= next_value;
      end
   end
   assign value_o = value;
endmodule

// ===== hw/cotr_trim_select.sv
// Picks the trim matching the input a converter is sampling
`timescale 1ns/1ps
module cotr_trim_select
   import cotr_pkg::*;
(
   input wire logic sys_clk_i, // Clock
   input wire logic reset_i, // Sync reset
   input wire logic [15:0] trim_a_i, // Trim for input A
   input wire logic [15:0] trim_b_i, // Trim for input B
   input wire logic sel_b_i, // Sampling input B
   output logic [11:0] trim_o // Applied trim
);
`include "cotr_params.svh"
   cotr_trim_t trim;
   cotr_trim_t next_trim;
   always_comb begin
      next_trim = sel_b_i ? trim_b_i[`COTR_TRIM_MSB:0] : trim_a_i[`COTR_TRIM_MSB:0];
   end
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         trim <= 12'h000;
      end else begin
         trim <= next_trim;
      end
   end
   assign trim_o = trim;
endmodule

// ===== hw/cotr_offset_trim_regs.sv
// Offset trim and offset filter control register bank
// What this block does
// - Separate trims for C/input B, B/input A and B/input B; converter B applies the one being sampled.
// - Trim lives in bits 11..0 and is unsigned.
// - Bits 15..12 are reserved read-write and reset to zero.
// - After reset each trim holds the factory value, software may overwrite.
// - Keep_near_zero_freq_content bit 0 only modifies filtering enabled by a separate bit.
// - Keep_near_zero_freq_content set: remove only bank mismatch, keep near-DC content.
// - Keep_near_zero_freq_content clear: remove all offsets, so all DC content.
// - Filter control 0 at 0x097 resets to 0x00, bits 7..1 reserved.
// - Filter control 1 at 0x098 resets to 0x33.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module cotr_offset_trim_regs
   import cotr_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic sys_clk_i, // 250 MHz clock
   input wire logic reset_i, // Sync reset, high
   input wire logic [ADDR_W-1:0] addr_i, // Byte address
   input wire logic [7:0] wdata_i, // Write data
   input wire logic wr_i, // Write strobe
   input wire logic rd_i, // Read strobe
   output logic [7:0] rdata_o, // Read data, cycle after strobe
   input wire logic [11:0] factory_c_inb_i, // Factory trim C/B
   input wire logic [11:0] factory_b_ina_i, // Factory trim B/A
   input wire logic [11:0] factory_b_inb_i, // Factory trim B/B
   input wire logic fg_run_i, // Foreground calibration running
   input wire logic foreground_complete_flag_i, // Foreground complete flag
   input wire logic cal_halted_i, // Calibration halted flag
   input wire logic conv_b_sel_inb_i, // Converter B samples input B
   output logic [11:0] conv_b_trim_o, // Trim applied to converter B
   output logic [11:0] conv_c_inb_trim_o, // Trim C for input B
   output logic [2:0] filt_mode_o, // Offset filter mode, one-hot
   output logic [7:0] filt_ctrl1_o, // Filter control 1 content
   output logic [3:0] cal_ctrl_o, // Calibration enables
   output logic wr_blocked_o // Last trim write was dropped
);
`include "cotr_params.svh"
   // Load factory trims once after reset release
   logic load_pend;
   logic next_load_pend;
   logic [7:0] filt0;
   logic [7:0] next_filt0;
   logic [7:0] filt1;
   logic [7:0] next_filt1;
   logic [3:0] cal_ctrl;
   logic [3:0] next_cal_ctrl;
   logic [7:0] rdata;
   logic [7:0] next_rdata;
   logic blocked;
   logic next_blocked;
   cotr_filt_mode_t filt_mode;
   cotr_filt_mode_t next_filt_mode;
   logic [2:0] st_sync1;
   logic [2:0] st_sync2;
   logic fg_run;
   logic foreground_complete_flag;
   logic cal_halted;
   logic trim_wr_ok;
   logic trim_addr;
   logic [11:0] a12;
   cotr_word_t c_inb;
   cotr_word_t b_ina;
   cotr_word_t b_inb;
   logic [11:0] b_trim;

   assign a12 = 12'(addr_i);

   // Status pins come from the calibration engine domain
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         st_sync1 <= 3'h0;
         st_sync2 <= 3'h0;
      end else begin
         st_sync1 <= {fg_run_i, cal_halted_i, foreground_complete_flag_i};
         st_sync2 <= st_sync1;
      end
   end
   assign fg_run = st_sync2[2];
   assign cal_halted = st_sync2[1];
   assign foreground_complete_flag = st_sync2[0];

   // Drop trim writes the calibration engine would fight
   always_comb begin
      trim_wr_ok = !fg_run;
      if (cal_ctrl[`COTR_BACKGROUND_CAL_ENABLE_BIT] && cal_ctrl[`COTR_BACKGROUND_OFFSET_CAL_ENABLE_BIT]) begin
         trim_wr_ok = 1'b0;
      end
   end
   assign trim_addr = (a12 >= `COTR_ADDR_C_INB_LO) && (a12 <= `COTR_ADDR_B_INB_HI);

   cotr_trim_reg u_c_inb (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .factory_i(factory_c_inb_i),
      .load_i(load_pend),
      .wr_lo_i(wr_i && trim_wr_ok && a12 == `COTR_ADDR_C_INB_LO),
      .wr_hi_i(wr_i && trim_wr_ok && a12 == `COTR_ADDR_C_INB_HI),
      .wdata_i(wdata_i),
      .value_o(c_inb)
   );
   cotr_trim_reg u_b_ina (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .factory_i(factory_b_ina_i),
      .load_i(load_pend),
      .wr_lo_i(wr_i && trim_wr_ok && a12 == `COTR_ADDR_B_INA_LO),
      .wr_hi_i(wr_i && trim_wr_ok && a12 == `COTR_ADDR_B_INA_HI),
      .wdata_i(wdata_i),
      .value_o(b_ina)
   );
   cotr_trim_reg u_b_inb (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .factory_i(factory_b_inb_i),
      .load_i(load_pend),
      .wr_lo_i(wr_i && trim_wr_ok && a12 == `COTR_ADDR_B_INB_LO),
      .wr_hi_i(wr_i && trim_wr_ok && a12 == `COTR_ADDR_B_INB_HI),
      .wdata_i(wdata_i),
      .value_o(b_inb)
   );
   cotr_trim_select u_b_sel (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .trim_a_i(b_ina),
      .trim_b_i(b_inb),
      .sel_b_i(conv_b_sel_inb_i),
      .trim_o(b_trim)
   );

   // Control registers and read path
   always_comb begin
      next_load_pend = 1'b0;
      next_filt0 = filt0;
      next_filt1 = filt1;
      next_cal_ctrl = cal_ctrl;
      next_blocked = blocked;
      next_rdata = 8'h00;
      if (wr_i) begin
         if (trim_addr) begin
            next_blocked = !trim_wr_ok;
         end
         case (a12)
            `COTR_ADDR_FILT0: next_filt0 = wdata_i;
            `COTR_ADDR_FILT1: next_filt1 = wdata_i;
            `COTR_ADDR_CAL_CTRL: next_cal_ctrl = wdata_i[3:0];
            default: ;
         endcase
      end
      if (rd_i) begin
         case (a12)
            `COTR_ADDR_C_INB_LO: next_rdata = c_inb[7:0];
            `COTR_ADDR_C_INB_HI: next_rdata = c_inb[15:8];
            `COTR_ADDR_B_INA_LO: next_rdata = b_ina[7:0];
            `COTR_ADDR_B_INA_HI: next_rdata = b_ina[15:8];
            `COTR_ADDR_B_INB_LO: next_rdata = b_inb[7:0];
            `COTR_ADDR_B_INB_HI: next_rdata = b_inb[15:8];
            `COTR_ADDR_FILT0: next_rdata = filt0;
            `COTR_ADDR_FILT1: next_rdata = filt1;
            `COTR_ADDR_CAL_CTRL: next_rdata = {4'h0, cal_ctrl};
            // Flags software polls before reading trims
            `COTR_ADDR_CAL_STAT: next_rdata = {4'h0, blocked, fg_run, cal_halted, foreground_complete_flag};
            default: next_rdata = 8'h00;
         endcase
      end
      // Filter mode only matters while filtering is enabled
      if (!cal_ctrl[`COTR_OFFSET_FILTER_ENABLE_BIT]) begin
         next_filt_mode = COTR_FILT_OFF;
      end else if (filt0[`COTR_KEEP_NEAR_ZERO_FREQ_CONTENT_BIT]) begin
         next_filt_mode = COTR_FILT_MISMATCH;
      end else begin
         next_filt_mode = COTR_FILT_ALL;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         load_pend <= 1'b1;
         filt0 <= `COTR_FILT0_RESET;
         filt1 <= `COTR_FILT1_RESET;
         cal_ctrl <= 4'h0;
         blocked <= 1'b0;
         rdata <= 8'h00;
         filt_mode <= COTR_FILT_OFF;
      end else begin
         load_pend <= next_load_pend;
         filt0 <= next_filt0;
         filt1 <= next_filt1;
         cal_ctrl <= next_cal_ctrl;
         blocked <= next_blocked;
         rdata <= next_rdata;
         filt_mode <= next_filt_mode;
      end
   end

   // Outputs straight from flops
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         conv_c_inb_trim_o <= 12'h000;
      end else begin
         conv_c_inb_trim_o <= c_inb[`COTR_TRIM_MSB:0];
      end
   end
   assign conv_b_trim_o = b_trim;
   assign rdata_o = rdata;
   assign filt_mode_o = filt_mode;
   assign filt_ctrl1_o = filt1;
   assign cal_ctrl_o = cal_ctrl;
   assign wr_blocked_o = blocked;
endmodule

// ===== verif/cotr_chk.sv
// Assertion checker for the offset trim bank
`timescale 1ns/1ps
`include "cotr_params.svh"
module cotr_chk
   import cotr_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic sys_clk_i, // Clock
   input wire logic reset_i, // Reset
   input wire logic [ADDR_W-1:0] addr_i, // Address
   input wire logic [7:0] wdata_i, // Write data
   input wire logic wr_i, // Write strobe
   input wire logic rd_i, // Read strobe
   input wire logic [7:0] rdata_o, // Read data
   input wire logic fg_run_i, // Foreground running
   input wire logic [11:0] conv_c_inb_trim_o, // Trim C/B
   input wire logic [2:0] filt_mode_o, // Filter mode
   input wire logic [7:0] filt_ctrl1_o, // Filter control 1
   input wire logic [3:0] cal_ctrl_o, // Cal enables
   input wire logic wr_blocked_o // Write dropped
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   sequence trim_wr;
      wr_i && addr_i >= `COTR_ADDR_C_INB_LO && addr_i <= `COTR_ADDR_B_INB_HI;
   endsequence
   sequence fg_quiet;
      (!fg_run_i)[*4] ##0 !(cal_ctrl_o[1] && cal_ctrl_o[2]);
   endsequence
   rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
      else $error("read data not zero when idle");
   filt1_reset_a: assert property ($fell(reset_i) |-> filt_ctrl1_o == `COTR_FILT1_RESET)
      else $error("filter control 1 reset value wrong");
   mode_hot_a: assert property ($onehot(filt_mode_o))
      else $error("filter mode not one-hot");
   mode_off_a: assert property ((!cal_ctrl_o[3])[*2] |-> filt_mode_o == COTR_FILT_OFF)
      else $error("filter active without enable");
   filt1_wr_a: assert property (wr_i && addr_i == `COTR_ADDR_FILT1 ##1 !wr_i
      |=> filt_ctrl1_o == $past(wdata_i, 2)) else $error("filter control 1 write lost");
   blocked_fg_a: assert property (fg_run_i[*4] ##0 trim_wr |=> wr_blocked_o)
      else $error("trim write during foreground run not dropped");
   pass_wr_a: assert property (fg_quiet ##0 trim_wr |=> !wr_blocked_o)
      else $error("legal trim write dropped");
   c_lo_wr_a: assert property (fg_quiet ##0 (wr_i && addr_i == `COTR_ADDR_C_INB_LO)
      ##1 !wr_i |=> conv_c_inb_trim_o[7:0] == $past(wdata_i, 2))
      else $error("low trim byte write lost");
endmodule

bind cotr_offset_trim_regs cotr_chk #(.ADDR_W(ADDR_W)) u_cotr_chk (.sys_clk_i(sys_clk_i),
   .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
   .rdata_o(rdata_o), .fg_run_i(fg_run_i), .conv_c_inb_trim_o(conv_c_inb_trim_o),
   .filt_mode_o(filt_mode_o), .filt_ctrl1_o(filt_ctrl1_o), .cal_ctrl_o(cal_ctrl_o),
   .wr_blocked_o(wr_blocked_o));

// ===== verif/cotr_offset_trim_regs_tb_top.sv
// Self-checking bench for the offset trim bank
`timescale 1ns/1ps
`include "cotr_params.svh"
module cotr_offset_trim_regs_tb_top
   import cotr_pkg::*;
   ;
   logic sys_clk_i = 0, reset_i = 1, wr_i = 0, rd_i = 0, fg_run_i = 0, sel_b = 0;
   logic foreground_complete_flag_i = 1, cal_halted_i = 1, wr_blocked_o;
   logic [11:0] addr_i = 0, fc, fa, fb, conv_b_trim_o, conv_c_inb_trim_o;
   logic [7:0] wdata_i = 0, rdata_o, filt_ctrl1_o, d;
   logic [2:0] filt_mode_o;
   logic [3:0] cal_ctrl_o;
   cotr_word_t mem [0:2];
   int fail_count = 0, comparisons = 0, cyc = 0, k;
   cotr_offset_trim_regs u_cotr_offset_trim_regs (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .factory_c_inb_i(fc), .factory_b_ina_i(fa), .factory_b_inb_i(fb), .fg_run_i(fg_run_i),
      .foreground_complete_flag_i(foreground_complete_flag_i), .cal_halted_i(cal_halted_i), .conv_b_sel_inb_i(sel_b),
      .conv_b_trim_o(conv_b_trim_o), .conv_c_inb_trim_o(conv_c_inb_trim_o),
      .filt_mode_o(filt_mode_o), .filt_ctrl1_o(filt_ctrl1_o), .cal_ctrl_o(cal_ctrl_o),
      .wr_blocked_o(wr_blocked_o));
   always #2 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         finish_test();
      end
   end
   function logic [2:0] exp_mode(input logic en, input logic dc);
      return en ? (dc ? COTR_FILT_MISMATCH : COTR_FILT_ALL) : COTR_FILT_OFF;
   endfunction
   task check(input string n, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s exp %h seen %h", n, exp, seen);
      end
   endtask
   task wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge sys_clk_i);
      wr_i <= 1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge sys_clk_i);
      wr_i <= 0;
   endtask
   task rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge sys_clk_i);
      rd_i <= 1;
      addr_i <= a;
      @(posedge sys_clk_i);
      rd_i <= 0;
      #1 check("rdata", {8'h00, rdata_o}, {8'h00, e});
   endtask
   // Trims are read only with both status flags high
   task chk_trims();
      rd(`COTR_ADDR_CAL_STAT, 8'h03);
      for (int j = 0; j < 3; j++) begin
         rd(12'h090 + 12'(2 * j), mem[j][7:0]);
         rd(12'h091 + 12'(2 * j), mem[j][15:8]);
      end
      for (int s = 0; s < 2; s++) begin
         @(posedge sys_clk_i);
         sel_b <= s[0];
         repeat (2) @(posedge sys_clk_i);
         #1 check("b_trim", 16'(conv_b_trim_o), 16'(s ? mem[2][11:0] : mem[1][11:0]));
      end
      check("c_trim", 16'(conv_c_inb_trim_o), 16'(mem[0][11:0]));
   endtask
   task finish_test();
      $display("checks %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      void'($urandom(32'h57ab));
      fc = 12'($urandom);
      fa = 12'($urandom);
      fb = 12'($urandom);
      mem[0] = {4'h0, fc};
      mem[1] = {4'h0, fa};
      mem[2] = {4'h0, fb};
      repeat (4) @(posedge sys_clk_i);
      reset_i <= 0;
      repeat (2) @(posedge sys_clk_i);
      rd(`COTR_ADDR_FILT0, `COTR_FILT0_RESET);
      rd(`COTR_ADDR_FILT1, `COTR_FILT1_RESET);
      rd(12'h0a5, 8'h00);
      chk_trims();
      $display("reset test done");
      for (int i = 0; i < 24; i++) begin
         k = $urandom_range(5);
         d = 8'($urandom);
         wr(12'h090 + 12'(k), d);
         if (k % 2) mem[k / 2][15:8] = d;
         else mem[k / 2][7:0] = d;
      end
      chk_trims();
      $display("trim write test done");
      fg_run_i <= 1;
      repeat (4) @(posedge sys_clk_i);
      wr(`COTR_ADDR_B_INA_LO, ~mem[1][7:0]);
      #1 check("blocked_fg", 16'(wr_blocked_o), 16'h0001);
      rd(`COTR_ADDR_CAL_STAT, 8'h0f);
      @(posedge sys_clk_i);
      fg_run_i <= 0;
      // Sticky flag must clear on a legal write before the next blocking case
      repeat (3) @(posedge sys_clk_i);
      wr(`COTR_ADDR_B_INA_LO, mem[1][7:0]);
      #1 check("unblocked_fg", 16'(wr_blocked_o), 16'h0000);
      wr(`COTR_ADDR_CAL_CTRL, 8'h06);
      repeat (4) @(posedge sys_clk_i);
      wr(`COTR_ADDR_B_INA_HI, ~mem[1][15:8]);
      #1 check("blocked_bg", 16'(wr_blocked_o), 16'h0001);
      rd(`COTR_ADDR_CAL_STAT, 8'h0b);
      wr(`COTR_ADDR_CAL_CTRL, 8'h02);
      #1 check("cal_ctrl", 16'(cal_ctrl_o), 16'h0002);
      repeat (2) @(posedge sys_clk_i);
      wr(`COTR_ADDR_B_INA_LO, 8'h5a);
      mem[1][7:0] = 8'h5a;
      #1 check("not_blocked", 16'(wr_blocked_o), 16'h0000);
      chk_trims();
      $display("blocking test done");
      d = 8'($urandom);
      wr(`COTR_ADDR_FILT1, d);
      rd(`COTR_ADDR_FILT1, d);
      for (int m = 0; m < 4; m++) begin
         d = {7'($urandom), m[0]};
         wr(`COTR_ADDR_CAL_CTRL, {4'h0, m[1], 3'b000});
         wr(`COTR_ADDR_FILT0, d);
         rd(`COTR_ADDR_FILT0, d);
         repeat (2) @(posedge sys_clk_i);
         #1 check("mode", 16'(filt_mode_o), 16'(exp_mode(m[1], m[0])));
      end
      $display("filter test done");
      finish_test();
   end
endmodule
